// ===== hw/calf_map.svh
// Function
// - AND sets H, parity, clears N and C
// - OR opcode 10110r, clears H N C
// - XOR opcode 10101r, clears H N C
// - INC: H from bit 3, V if 7F
// - decrement 00r101: H borrow bit 4, V if 80
// - compare subtracts for flags, borrow to C
// - compare immediate FE keeps accumulator
// - ones complement sets H and N only
// - negate: 0 minus A, 8 T-states
// - carry invert: H gets old carry
// - decimal adjust after add: 06/60/66
// - decimal adjust after subtract: FA/A0/9A
// - decimal adjust S Z parity, 4 T-states
// - immediate forms take next byte, 7 T-states
// - 8-bit add: H bit 3, V, C bit 7
// - memory forms 7 T, indexed 19 T; inc/dec memory 11 T, indexed 23 T
// - subtract with borrow: A minus m minus C
// - register field 111 accumulator, 110 memory
`ifndef CALF_MAP_SVH
`define CALF_MAP_SVH
// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define CALF_A_ACC 8'h00
`define CALF_A_FLAGS 8'h04
`define CALF_A_OPR 8'h08
`define CALF_A_PTR 8'h0C
`define CALF_A_WOPR 8'h10
`define CALF_A_CMD 8'h14
`define CALF_A_STAT 8'h18
// ----------------------------------------------------------------
// flag bit positions and reset values
// ----------------------------------------------------------------
`define CALF_F_S 7
`define CALF_F_Z 6
`define CALF_F_H 4
`define CALF_F_V 2
`define CALF_F_N 1
`define CALF_F_C 0
`define CALF_RST8 8'h00
`define CALF_RST16 16'h0000
// ----------------------------------------------------------------
// opcodes, prefixes, fields
// ----------------------------------------------------------------
`define CALF_PFX_NONE 8'h00
`define CALF_PFX_EXT 8'hED
`define CALF_PFX_IX 8'hDD
`define CALF_PFX_IY 8'hFD
`define CALF_OP_ONES 8'h2F
`define CALF_OP_CINV 8'h3F
`define CALF_OP_CSET 8'h37
`define CALF_OP_DADJ 8'h27
`define CALF_OP_NEGATE 8'h44
`define CALF_R_MEM 3'b110
`define CALF_R_ACC 3'b111
`define CALF_PAIR_PTR 2'b10
// ----------------------------------------------------------------
// T-state counts
// ----------------------------------------------------------------
`define CALF_T_REG 5'd4
`define CALF_T_IMM 5'd7
`define CALF_T_MEM 5'd7
`define CALF_T_IDX 5'd19
`define CALF_T_NEGATE 5'd8
`define CALF_T_NONE 5'd0
`define CALF_T_INCM 5'd11
`define CALF_T_INCX 5'd23
`define CALF_T_ADDW 5'd11
`define CALF_T_ADDWX 5'd15
`define CALF_T_WIDE 5'd15
`define CALF_T_INCW 5'd6
`define CALF_T_INCWX 5'd10
// ----------------------------------------------------------------
// decimal adjust corrections and thresholds, step and overflow constants
// ----------------------------------------------------------------
`define CALF_DA_LO 8'h06
`define CALF_DA_HI 8'h60
`define CALF_DA_LO_S 8'hFA
`define CALF_DA_HI_S 8'hA0
`define CALF_NIB9 4'h9
`define CALF_BYTE99 8'h99
`define CALF_ONE8 8'h01
`define CALF_ONE16 16'h0001
`define CALF_V_INC 8'h7F
`define CALF_V_DECR 8'h80
`define CALF_NIB6 4'h6
`endif

// ===== hw/calf_pkg.sv
package calf_pkg;
  // 8-bit operation selected by opcode bits 5..3
  typedef enum logic [2:0] {
    ALU_ADD, ALU_ADC, ALU_SUB, ALU_SUBC, ALU_AND, ALU_XOR, ALU_OR, ALU_CMP
  } calf_alu_t;

  // one apb request as seen by the slave
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } calf_apb_t;

  // whole state of the unit
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] flags;
    logic [7:0] opr;
    logic [15:0] ptr;
    logic [15:0] wopr;
    logic [15:0] cmd;
    logic [4:0] tstates;
    logic illegal;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } calf_state_t;
endpackage

// ===== hw/calf_adder.sv
`timescale 1ns/10ps
// add or subtract with carry-in, reporting carry/borrow, half and overflow
module calf_adder #(
  parameter int W = 8,
  parameter int HB = 4
) (
  // operands
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  input wire logic cin,
  input wire logic sub,
  // results
  output logic [W-1:0] sum,
  output logic carry,
  output logic half,
  output logic ovf
);
  logic [W-1:0] bx;
  logic cx;
  logic [W:0] full;
  logic [HB:0] low;

  // subtraction as a plus inverted b plus inverted borrow-in
  assign bx = sub ? ~b : b;
  assign cx = sub ? ~cin : cin;
  assign full = {1'b0, a} + {1'b0, bx} + {{W{1'b0}}, cx};
  assign low = {1'b0, a[HB-1:0]} + {1'b0, bx[HB-1:0]} + {{HB{1'b0}}, cx};
  assign sum = full[W-1:0];
  // borrow is the inverted carry out
  assign carry = full[W] ^ sub;
  assign half = low[HB] ^ sub;
  assign ovf = (a[W-1] == bx[W-1]) && (full[W-1] != a[W-1]);
endmodule // calf_adder

// ===== hw/calf_unit.sv
`timescale 1ns/10ps
`include "calf_map.svh"
// arithmetic, logic and flag unit behind an apb slave
module calf_unit (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  // live view of accumulator and flags
  output logic [7:0] ACC_OUT,
  output logic [7:0] FLAGS_OUT
);
  calf_pkg::calf_state_t s_reg;
  calf_pkg::calf_state_t s_next;
  calf_pkg::calf_apb_t req;

  // ----------------------------------------------------------------
  // command decode from write data
  // ----------------------------------------------------------------
  logic [7:0] pfx;
  logic [7:0] opc;
  logic [2:0] rfld;
  logic [1:0] pair_sel;
  logic idx;
  logic ext;
  logic is_alu_r;
  logic is_alu_n;
  logic is_inc;
  logic is_decr;
  logic is_addw;
  logic is_incw;
  logic is_decw;
  logic is_adcw;
  logic is_sbcw;
  logic is_negate;
  calf_pkg::calf_alu_t aop;
  logic [7:0] tgt8;
  logic [7:0] src8;
  logic [15:0] srcw;
  logic [15:0] tgtw;

  assign req = '{psel: PSEL, penable: PENABLE, pwrite: PWRITE,
                 paddr: PADDR, pwdata: PWDATA};
  assign pfx = req.pwdata[15:8];
  assign opc = req.pwdata[7:0];
  assign rfld = opc[2:0];
  assign pair_sel = opc[5:4];
  assign idx = (pfx == `CALF_PFX_IX) || (pfx == `CALF_PFX_IY);
  assign ext = (pfx == `CALF_PFX_EXT);
  assign aop = calf_pkg::calf_alu_t'(opc[5:3]);
  assign is_alu_r = !ext && (opc[7:6] == 2'b10);
  assign is_alu_n = !ext && (opc[7:6] == 2'b11) && (rfld == `CALF_R_MEM);
  assign is_inc = !ext && (opc[7:6] == 2'b00) && (rfld == 3'b100);
  assign is_decr = !ext && (opc[7:6] == 2'b00) && (rfld == 3'b101);
  assign is_addw = !ext && (opc[7:6] == 2'b00) && (opc[3:0] == 4'b1001);
  assign is_incw = !ext && (opc[7:6] == 2'b00) && (opc[3:0] == 4'b0011);
  assign is_decw = !ext && (opc[7:6] == 2'b00) && (opc[3:0] == 4'b1011);
  assign is_adcw = ext && (opc[7:6] == 2'b01) && (opc[3:0] == 4'b1010);
  assign is_sbcw = ext && (opc[7:6] == 2'b01) && (opc[3:0] == 4'b0010);
  assign is_negate = ext && (opc == `CALF_OP_NEGATE);

  // register field: all ones is the accumulator, 110 the memory byte
  assign tgt8 = (opc[5:3] == `CALF_R_ACC) ? s_reg.acc : s_reg.opr;
  assign src8 = (rfld == `CALF_R_ACC && is_alu_r) ? s_reg.acc : s_reg.opr;
  // pair field 10 selects the pointer pair itself
  assign srcw = (pair_sel == `CALF_PAIR_PTR) ? s_reg.ptr : s_reg.wopr;
  assign tgtw = (pair_sel == `CALF_PAIR_PTR) ? s_reg.ptr : s_reg.wopr;

  // ----------------------------------------------------------------
  // shared adders
  // ----------------------------------------------------------------
  logic [7:0] a8;
  logic [7:0] b8;
  logic c8;
  logic sub8;
  logic [7:0] sum8;
  logic cy8;
  logic hc8;
  logic ov8;
  logic [15:0] b16;
  logic c16;
  logic sub16;
  logic [15:0] sum16;
  logic cy16;
  logic hc16;
  logic ov16;
  logic alu_arith;
  logic alu_sub;

  assign alu_sub = (aop == calf_pkg::ALU_SUB) || (aop == calf_pkg::ALU_SUBC) ||
                   (aop == calf_pkg::ALU_CMP);
  assign alu_arith = (aop == calf_pkg::ALU_ADC) || (aop == calf_pkg::ALU_SUBC);

  // operand steering for the byte adder
  always_comb begin
    a8 = s_reg.acc;
    b8 = src8;
    c8 = 1'b0;
    sub8 = 1'b0;
    if (is_negate) begin
      a8 = `CALF_RST8;
      b8 = s_reg.acc;
      sub8 = 1'b1;
    end else if (is_inc || is_decr) begin
      a8 = tgt8;
      b8 = `CALF_ONE8;
      sub8 = is_decr;
    end else begin
      c8 = alu_arith & s_reg.flags[`CALF_F_C];
      sub8 = alu_sub;
    end
  end

  assign b16 = srcw;
  assign c16 = (is_adcw || is_sbcw) & s_reg.flags[`CALF_F_C];
  assign sub16 = is_sbcw;

  calf_adder #(.W(8), .HB(4)) u_add8 (
    .a(a8),
    .b(b8),
    .cin(c8),
    .sub(sub8),
    .sum(sum8),
    .carry(cy8),
    .half(hc8),
    .ovf(ov8)
  );

  // half from bit 11 on add, borrow from bit 12 on subtract
  calf_adder #(.W(16), .HB(12)) u_add16 (
    .a(s_reg.ptr),
    .b(b16),
    .cin(c16),
    .sub(sub16),
    .sum(sum16),
    .carry(cy16),
    .half(hc16),
    .ovf(ov16)
  );

  // ----------------------------------------------------------------
  // decimal adjust
  // ----------------------------------------------------------------
  logic da_lo;
  logic da_hi;
  logic [7:0] da_corr;
  logic [7:0] da_res;
  logic da_h;

  // add mode: prior H and C or digits above nine; subtract mode: only prior C and H
  always_comb begin
    if (s_reg.flags[`CALF_F_N]) begin
      da_lo = s_reg.flags[`CALF_F_H];
      da_hi = s_reg.flags[`CALF_F_C];
      da_corr = (da_lo ? `CALF_DA_LO_S : `CALF_RST8) +
                (da_hi ? `CALF_DA_HI_S : `CALF_RST8);
      da_h = s_reg.flags[`CALF_F_H] && (s_reg.acc[3:0] < `CALF_NIB6);
    end else begin
      da_lo = s_reg.flags[`CALF_F_H] || (s_reg.acc[3:0] > `CALF_NIB9);
      da_hi = s_reg.flags[`CALF_F_C] || (s_reg.acc > `CALF_BYTE99);
      da_corr = (da_lo ? `CALF_DA_LO : `CALF_RST8) +
                (da_hi ? `CALF_DA_HI : `CALF_RST8);
      da_h = s_reg.acc[3:0] > `CALF_NIB9;
    end
  end
  assign da_res = s_reg.acc + da_corr;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic hit;
  logic [31:0] rd;

  always_comb begin
    hit = 1'b1;
    rd = 32'h0000_0000;
    if (req.paddr == `CALF_A_ACC) begin
      rd[7:0] = s_reg.acc;
    end else if (req.paddr == `CALF_A_FLAGS) begin
      rd[7:0] = s_reg.flags;
    end else if (req.paddr == `CALF_A_OPR) begin
      rd[7:0] = s_reg.opr;
    end else if (req.paddr == `CALF_A_PTR) begin
      rd[15:0] = s_reg.ptr;
    end else if (req.paddr == `CALF_A_WOPR) begin
      rd[15:0] = s_reg.wopr;
    end else if (req.paddr == `CALF_A_CMD) begin
      rd[15:0] = s_reg.cmd;
    end else if (req.paddr == `CALF_A_STAT) begin
      rd[4:0] = s_reg.tstates;
      rd[8] = s_reg.illegal;
    end else begin
      hit = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [7:0] fl;
  logic [7:0] r8;
  logic commit;

  assign fl = s_reg.flags;
  assign commit = req.psel && req.penable && s_reg.pready;

  always_comb begin
    s_next = s_reg;
    r8 = `CALF_RST8;
    // one wait state: answer is prepared, then the access completes
    s_next.pready = 1'b0;
    if (req.psel && req.penable && !s_reg.pready) begin
      s_next.pready = 1'b1;
      s_next.pslverr = !hit;
      s_next.prdata = req.pwrite ? 32'h0000_0000 : rd;
    end
    if (commit && req.pwrite && hit) begin
      if (req.paddr == `CALF_A_ACC) begin
        s_next.acc = req.pwdata[7:0];
      end else if (req.paddr == `CALF_A_FLAGS) begin
        s_next.flags = req.pwdata[7:0];
      end else if (req.paddr == `CALF_A_OPR) begin
        s_next.opr = req.pwdata[7:0];
      end else if (req.paddr == `CALF_A_PTR) begin
        s_next.ptr = req.pwdata[15:0];
      end else if (req.paddr == `CALF_A_WOPR) begin
        s_next.wopr = req.pwdata[15:0];
      end else if (req.paddr == `CALF_A_CMD) begin
        s_next.cmd = req.pwdata[15:0];
        s_next.illegal = 1'b0;
        if (is_alu_r || is_alu_n) begin
          // result of the selected operation
          case (aop)
            calf_pkg::ALU_AND: r8 = s_reg.acc & src8;
            calf_pkg::ALU_XOR: r8 = s_reg.acc ^ src8;
            calf_pkg::ALU_OR: r8 = s_reg.acc | src8;
            default: r8 = sum8;
          endcase
          s_next.flags[`CALF_F_S] = r8[7];
          s_next.flags[`CALF_F_Z] = (r8 == `CALF_RST8);
          if (aop == calf_pkg::ALU_AND || aop == calf_pkg::ALU_XOR ||
              aop == calf_pkg::ALU_OR) begin
            s_next.flags[`CALF_F_H] = (aop == calf_pkg::ALU_AND);
            s_next.flags[`CALF_F_V] = ~^r8;
            s_next.flags[`CALF_F_N] = 1'b0;
            s_next.flags[`CALF_F_C] = 1'b0;
          end else begin
            s_next.flags[`CALF_F_H] = hc8;
            s_next.flags[`CALF_F_V] = ov8;
            s_next.flags[`CALF_F_N] = alu_sub;
            s_next.flags[`CALF_F_C] = cy8;
          end
          // compare leaves the accumulator alone
          if (aop != calf_pkg::ALU_CMP) begin
            s_next.acc = r8;
          end
          if (is_alu_n) begin
            s_next.tstates = `CALF_T_IMM;
          end else if (rfld == `CALF_R_MEM) begin
            s_next.tstates = idx ? `CALF_T_IDX : `CALF_T_MEM;
          end else begin
            s_next.tstates = `CALF_T_REG;
          end
        end else if (is_inc || is_decr) begin
          s_next.flags[`CALF_F_S] = sum8[7];
          s_next.flags[`CALF_F_Z] = (sum8 == `CALF_RST8);
          s_next.flags[`CALF_F_H] = hc8;
          s_next.flags[`CALF_F_N] = is_decr;
          // carry stays as it was
          s_next.flags[`CALF_F_V] = is_decr ? (tgt8 == `CALF_V_DECR) :
                                             (tgt8 == `CALF_V_INC);
          if (opc[5:3] == `CALF_R_ACC) begin
            s_next.acc = sum8;
          end else begin
            s_next.opr = sum8;
          end
          if (opc[5:3] == `CALF_R_MEM) begin
            s_next.tstates = idx ? `CALF_T_INCX : `CALF_T_INCM;
          end else begin
            s_next.tstates = `CALF_T_REG;
          end
        end else if (is_negate) begin
          s_next.acc = sum8;
          s_next.flags[`CALF_F_S] = sum8[7];
          s_next.flags[`CALF_F_Z] = (sum8 == `CALF_RST8);
          s_next.flags[`CALF_F_H] = hc8;
          s_next.flags[`CALF_F_V] = (s_reg.acc == `CALF_V_DECR);
          s_next.flags[`CALF_F_N] = 1'b1;
          s_next.flags[`CALF_F_C] = (s_reg.acc != `CALF_RST8);
          s_next.tstates = `CALF_T_NEGATE;
        end else if (!ext && opc == `CALF_OP_ONES) begin
          s_next.acc = ~s_reg.acc;
          s_next.flags[`CALF_F_H] = 1'b1;
          s_next.flags[`CALF_F_N] = 1'b1;
          s_next.tstates = `CALF_T_REG;
        end else if (!ext && opc == `CALF_OP_CINV) begin
          s_next.flags[`CALF_F_H] = fl[`CALF_F_C];
          s_next.flags[`CALF_F_C] = ~fl[`CALF_F_C];
          s_next.flags[`CALF_F_N] = 1'b0;
          s_next.tstates = `CALF_T_REG;
        end else if (!ext && opc == `CALF_OP_CSET) begin
          s_next.flags[`CALF_F_C] = 1'b1;
          s_next.flags[`CALF_F_H] = 1'b0;
          s_next.flags[`CALF_F_N] = 1'b0;
          s_next.tstates = `CALF_T_REG;
        end else if (!ext && opc == `CALF_OP_DADJ) begin
          s_next.acc = da_res;
          s_next.flags[`CALF_F_S] = da_res[7];
          s_next.flags[`CALF_F_Z] = (da_res == `CALF_RST8);
          s_next.flags[`CALF_F_V] = ~^da_res;
          s_next.flags[`CALF_F_H] = da_h;
          // subtract mode keeps carry; add mode sets it on upper fix
          s_next.flags[`CALF_F_C] = fl[`CALF_F_N] ? fl[`CALF_F_C] : da_hi;
          s_next.tstates = `CALF_T_REG;
        end else if (is_addw) begin
          s_next.ptr = sum16;
          s_next.flags[`CALF_F_H] = hc16;
          s_next.flags[`CALF_F_N] = 1'b0;
          s_next.flags[`CALF_F_C] = cy16;
          s_next.tstates = idx ? `CALF_T_ADDWX : `CALF_T_ADDW;
        end else if (is_adcw || is_sbcw) begin
          s_next.ptr = sum16;
          s_next.flags[`CALF_F_S] = sum16[15];
          s_next.flags[`CALF_F_Z] = (sum16 == `CALF_RST16);
          s_next.flags[`CALF_F_H] = hc16;
          s_next.flags[`CALF_F_V] = ov16;
          s_next.flags[`CALF_F_N] = is_sbcw;
          s_next.flags[`CALF_F_C] = cy16;
          s_next.tstates = `CALF_T_WIDE;
        end else if (is_incw || is_decw) begin
          // no flag changes at all
          if (pair_sel == `CALF_PAIR_PTR) begin
            s_next.ptr = is_decw ? tgtw - `CALF_ONE16 : tgtw + `CALF_ONE16;
          end else begin
            s_next.wopr = is_decw ? tgtw - `CALF_ONE16 : tgtw + `CALF_ONE16;
          end
          s_next.tstates = idx ? `CALF_T_INCWX : `CALF_T_INCW;
        end else begin
          // unknown code: only the marker is set and the T-state count cleared
          s_next.illegal = 1'b1;
          s_next.tstates = `CALF_T_NONE;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs come straight from the state flops
  assign PREADY = s_reg.pready;
  assign PRDATA = s_reg.prdata;
  assign PSLVERR = s_reg.pslverr;
  assign ACC_OUT = s_reg.acc;
  assign FLAGS_OUT = s_reg.flags;
endmodule // calf_unit

// ===== test/calf_unit_assertions.sv
`timescale 1ns/10ps
`include "calf_map.svh"
// --------
// flag and result relations one cycle after a command is taken
// --------
module calf_unit_assertions (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic [31:0] PRDATA,
  input wire logic PSLVERR,
  // live view
  input wire logic [7:0] ACC_OUT,
  input wire logic [7:0] FLAGS_OUT
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  // command write completing at this edge; results land on it
  logic go;
  logic [15:0] op;
  assign go = PSEL && PENABLE && PREADY && PWRITE && PADDR == `CALF_A_CMD;
  assign op = PWDATA[15:0];
  a_and_flags: assert property (
    go && op[15:3] == 13'h0014 |=> FLAGS_OUT[4] && !FLAGS_OUT[1] && !FLAGS_OUT[0]
    && FLAGS_OUT[2] == ~^ACC_OUT) else $error("and flags wrong");
  a_or_flags: assert property (
    go && op[15:3] == 13'h0016 |=> (FLAGS_OUT & 8'h13) == 8'h00
    && FLAGS_OUT[2] == ~^ACC_OUT) else $error("or flags wrong");
  a_xor_flags: assert property (
    go && op[15:3] == 13'h0015 |=> (FLAGS_OUT & 8'h13) == 8'h00
    && FLAGS_OUT[2] == ~^ACC_OUT) else $error("xor flags wrong");
  a_cmp_keeps_acc: assert property (
    go && (op[15:3] == 13'h0017 || op == 16'h00FE) |=> $stable(ACC_OUT) && FLAGS_OUT[1])
    else $error("compare changed accumulator");
  a_ones_invert: assert property (
    go && op == 16'h002F |=> ACC_OUT == ~$past(ACC_OUT) && (FLAGS_OUT & 8'h12) == 8'h12
    && (FLAGS_OUT & 8'hC5) == ($past(FLAGS_OUT) & 8'hC5)) else $error("invert wrong");
  a_negate_value: assert property (
    go && op == 16'hED44 |=> ACC_OUT == 8'h00 - $past(ACC_OUT)
    && FLAGS_OUT[0] == ($past(ACC_OUT) != 8'h00) && FLAGS_OUT[2] == ($past(ACC_OUT) == 8'h80))
    else $error("negate wrong");
  a_carry_swap: assert property (
    go && op == 16'h003F |=> FLAGS_OUT[0] != $past(FLAGS_OUT[0])
    && FLAGS_OUT[4] == $past(FLAGS_OUT[0]) && !FLAGS_OUT[1]) else $error("carry invert wrong");
  a_carry_force: assert property (
    go && op == 16'h0037 |=> (FLAGS_OUT & 8'h13) == 8'h01
    && (FLAGS_OUT & 8'hC4) == ($past(FLAGS_OUT) & 8'hC4)) else $error("carry force wrong");
  a_adjust_flags: assert property (
    go && op == 16'h0027 |=> FLAGS_OUT[7] == ACC_OUT[7] && FLAGS_OUT[6] == (ACC_OUT == 8'h00)
    && FLAGS_OUT[2] == ~^ACC_OUT && $stable(FLAGS_OUT[1])) else $error("adjust flags wrong");
  a_wide_step_flags: assert property (
    go && (op[7:0] & 8'hC7) == 8'h03 |=> $stable(FLAGS_OUT))
    else $error("wide step touched flags");
  // main scenarios reached
  c_negate: cover property (go && op == 16'hED44);
  c_adjust: cover property (go && op == 16'h0027);
  c_refused: cover property (PREADY && PSLVERR);
endmodule // calf_unit_assertions

// ===== test/calf_seq_model.sv
`timescale 1ns/10ps
// --------
// apb master standing in for the fetch and decode sequencer
// --------
module calf_seq_model (
  // clock
  input wire logic clk,
  // slave answer
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // request
  output calf_pkg::calf_apb_t apb
);
  // idle bus at time zero
  initial apb = '0;
  // one transfer, held until pready is seen high at a rising edge or 40 edges pass
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic err, output logic to);
    int n;
    @(posedge clk);
    apb <= '{1'b1, 1'b0, w, a, wd};
    @(posedge clk);
    apb.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    to = pready !== 1'b1;
    rd = prdata;
    err = pslverr;
    // released lines turn over, so a slave latching late cannot pass
    apb <= '{1'b0, 1'b0, ~w, ~a, ~wd};
  endtask
endmodule // calf_seq_model

// ===== test/tb_top.sv
`timescale 1ns/10ps
`include "calf_map.svh"
// --------
// self-checking bench for the arithmetic and flag unit
// --------
module tb_top;
  logic clk;
  logic rst;
  calf_pkg::calf_apb_t apb;
  logic pready;
  logic pslverr;
  logic [31:0] prdata;
  logic [7:0] acc_out;
  logic [7:0] flags_out;
  int error_cnt;
  int checked;
  // partner and unit
  calf_seq_model i_calf_seq_model (.clk(clk), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .apb(apb));
  calf_unit i_calf_unit (.CLK(clk), .RST(rst), .PSEL(apb.psel), .PENABLE(apb.penable),
    .PWRITE(apb.pwrite), .PADDR(apb.paddr), .PWDATA(apb.pwdata), .PREADY(pready),
    .PRDATA(prdata), .PSLVERR(pslverr), .ACC_OUT(acc_out), .FLAGS_OUT(flags_out));
  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic final_report();
    if (error_cnt == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // a hung slave ends the run here rather than stalling forever
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] d, output logic e);
    logic t;
    i_calf_seq_model.xfer(w, a, wd, d, e, t);
    if (t !== 1'b0) begin
      error_cnt++;
      final_report();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    logic e;
    bus(1'b1, a, wd, d, e);
  endtask
  // v: command, acc, flags, operand, then expected acc, flags, operand
  task automatic run(input logic [63:0] v, input logic [4:0] t);
    logic [31:0] d;
    logic e;
    wr(`CALF_A_ACC, 32'(v[47:40]));
    wr(`CALF_A_FLAGS, 32'(v[39:32]));
    wr(`CALF_A_OPR, 32'(v[31:24]));
    wr(`CALF_A_CMD, 32'(v[63:48]));
    @(negedge clk);
    cmp(32'(acc_out), 32'(v[23:16]));
    bus(1'b0, `CALF_A_FLAGS, '0, d, e);
    cmp(d & 32'h0000_00D7, 32'(v[15:8]));
    bus(1'b0, `CALF_A_OPR, '0, d, e);
    cmp(d, 32'(v[7:0]));
    bus(1'b0, `CALF_A_STAT, '0, d, e);
    cmp(d, 32'(t));
  endtask
  // v: command, pointer, wide operand, expected pointer, flags, expected flags
  task automatic run16(input logic [79:0] v, input logic [4:0] t);
    logic [31:0] d;
    logic e;
    wr(`CALF_A_PTR, 32'(v[63:48]));
    wr(`CALF_A_WOPR, 32'(v[47:32]));
    wr(`CALF_A_FLAGS, 32'(v[15:8]));
    wr(`CALF_A_CMD, 32'(v[79:64]));
    bus(1'b0, `CALF_A_PTR, '0, d, e);
    cmp(d, 32'(v[31:16]));
    bus(1'b0, `CALF_A_FLAGS, '0, d, e);
    cmp(d & 32'h0000_00D7, 32'(v[7:0]));
    bus(1'b0, `CALF_A_STAT, '0, d, e);
    cmp(d, 32'(t));
  endtask
  task automatic sc_bus();
    logic [31:0] d;
    logic e;
    // every mapped place reads zero after reset, without error
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, 8'(4 * i), '0, d, e);
      cmp(d, '0);
      cmp_bit(e, 1'b0);
    end
    // unmapped place refuses both directions
    bus(1'b1, 8'h1C, 32'hFFFF_FFFF, d, e);
    cmp_bit(e, 1'b1);
    bus(1'b0, 8'h1C, '0, d, e);
    cmp_bit(e, 1'b1);
    cmp(d, '0);
    // status stays read-only; an unknown code is marked illegal
    wr(`CALF_A_STAT, 32'hFFFF_FFFF);
    wr(`CALF_A_CMD, 32'h0000_ED00);
    bus(1'b0, `CALF_A_STAT, '0, d, e);
    cmp(d, 32'h0000_0100);
    bus(1'b0, `CALF_A_CMD, '0, d, e);
    cmp(d, 32'h0000_ED00);
  endtask
  task automatic sc_logic();
    run(64'h00A0_F003_3C30_143C, 5'd4);
    run(64'h00B0_0013_0000_4400, 5'd4);
    run(64'h00A8_FF13_807F_0080, 5'd4);
    run(64'h00AF_5A00_FF00_44FF, 5'd4);
    run(64'h00B8_1000_2010_8320, 5'd4);
    run(64'h00FE_8000_0180_1601, 5'd7);
    run(64'h00F6_0100_0203_0402, 5'd7);
    run(64'h00E6_FF00_8181_9481, 5'd7);
  endtask
  // boundary values on both sides of the increment overflow point; decrement at 80 and 01
  task automatic sc_incdec();
    run(64'h0004_0001_7F00_9580, 5'd4);
    run(64'h0004_0000_7E00_007F, 5'd4);
    run(64'h003C_FF00_0000_5000, 5'd4);
    run(64'h0005_0000_8000_167F, 5'd4);
    run(64'h0005_0001_0100_4300, 5'd4);
  endtask
  task automatic sc_special();
    run(64'h002F_5AC5_00A5_D700, 5'd4);
    run(64'hED44_8000_0080_8700, 5'd8);
    run(64'hED44_0001_0000_4200, 5'd8);
    run(64'hED44_0100_00FF_9300, 5'd8);
    run(64'h003F_00C5_0000_D400, 5'd4);
    run(64'h003F_0002_0000_0100, 5'd4);
    run(64'h0037_00D6_0000_C500, 5'd4);
  endtask
  task automatic sc_decimal();
    run(64'h0027_0B00_0011_1400, 5'd4);
    run(64'h0027_A500_0005_0500, 5'd4);
    run(64'h0027_9A00_0000_5500, 5'd4);
    run(64'h0027_2111_0087_8500, 5'd4);
    run(64'h0027_0F12_0009_0600, 5'd4);
    run(64'h0027_7503_0015_0300, 5'd4);
    run(64'h0027_6613_0000_4700, 5'd4);
  endtask
  task automatic sc_memory();
    run(64'h0086_7F00_0180_9401, 5'd7);
    run(64'hDD86_FF00_0100_5101, 5'd19);
    run(64'hFD86_8000_8000_4580, 5'd19);
    run(64'h0088_0F01_0010_1000, 5'd4);
    run(64'h00D6_2000_011F_1201, 5'd7);
    run(64'h0034_0000_0F00_1010, 5'd11);
    run(64'hDD35_0000_0100_4200, 5'd23);
    run(64'h009E_0001_00FF_9300, 5'd7);
    run(64'hDD9E_8001_007F_1600, 5'd19);
  endtask
  task automatic sc_wide();
    run16(80'hED4A_0FFF_0001_1000_0010, 5'd15);
    run16(80'hED4A_FFFF_0000_0000_0151, 5'd15);
    run16(80'hED6A_4000_0000_8000_0084, 5'd15);
    run16(80'hED52_1000_0001_0FFF_0012, 5'd15);
    run16(80'hED42_0000_0000_FFFF_0193, 5'd15);
    run16(80'h0023_FFFF_0000_0000_D7D7, 5'd6);
    run16(80'h002B_0000_0000_FFFF_0000, 5'd6);
    run16(80'hDD23_1234_0000_1235_0000, 5'd10);
    run16(80'h0009_0FFF_0001_1000_C5D4, 5'd11);
    run16(80'hDD29_8000_0000_0000_0001, 5'd15);
  endtask
  // reset for 12 cycles, then every scenario in turn
  initial begin
    error_cnt = 0;
    checked = 0;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    sc_bus();
    sc_logic();
    sc_incdec();
    sc_special();
    sc_decimal();
    sc_memory();
    sc_wide();
    final_report();
  end
endmodule // tb_top
bind calf_unit calf_unit_assertions i_calf_unit_assertions (.CLK(CLK), .RST(RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR), .ACC_OUT(ACC_OUT),
  .FLAGS_OUT(FLAGS_OUT));
